// ===== hdl/pwm8_pkg.sv
// Purpose: Shared constants and carriers for the 8-bit width modulator
// Assumes: One counter-array clock, active-low async reset
// Notes:   Cycle length select encodings follow the shared config field
package pwm8_pkg;

    localparam logic [1:0] CYCLE_LEN_8BIT = 2'h0;
    localparam logic [7:0] BYTE_MAX     = 8'hff;
    localparam logic [7:0] BYTE_ZERO    = 8'h00;
    localparam logic [7:0] BYTE_ONE     = 8'h01;

    // Software writes to one channel's compare pair
    typedef struct packed {
        logic       wr_low;
        logic       wr_high;
        logic [7:0] wdata;
    } compare_write_t;

    // Per-channel mode bits
    typedef struct packed {
        logic       width_mod_select;
        logic       match_flag_enable;
    } channel_mode_t;

    // Visible channel state
    typedef struct packed {
        logic       comparator_enable;
        logic [7:0] compare_low_byte;
        logic [7:0] compare_high_byte;
    } channel_state_t;

endpackage

// ===== hdl/pwm8_timebase.sv
// Purpose: Free-running counter low byte with wrap detection
// Assumes: Advances once per enabled counter-array clock
// Notes:   Wrap pulse marks the step from all ones to zero
`timescale 1ns/1ps
module pwm8_timebase (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_arst_n,
    input  wire logic       i_ce,
    // Count control
    input  wire logic       i_run,
    // Counter state
    output logic [7:0]      o_count,
    output logic            o_wrap
);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_count <= pwm8_pkg::BYTE_ZERO;
        end else if (i_ce && i_run) begin
            o_count <= o_count + pwm8_pkg::BYTE_ONE;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wrap <= 1'b0;
        end else if (i_ce) begin
            o_wrap <= i_run && (o_count == pwm8_pkg::BYTE_MAX);
        end
    end

endmodule

// ===== hdl/pwm8_channel.sv
// Purpose: One counter-array channel in 8-bit width modulation mode
// Assumes: Counter low byte produced locally by pwm8_timebase
// Notes:   Other cycle lengths and a cleared select drive the pin low
`timescale 1ns/1ps

// How it works
// - The channel drives its own output pin with a modulated waveform.
// - All modulating channels share the one cycle length select field.
// - Outside the shared-length mode the pin is driven low and only the overflow flag still sets.
// - The pin goes high when the counter low byte equals compare low.
// - The pin goes low when the counter low byte overflows.
// - On the wrap to zero compare low is reloaded from compare high.
// - Mode is on with enable and select set and length select zero.
// - With match flag enable set each match while the pin is low sets the event flag.
// - Each low-byte overflow sets the cycle overflow flag.
// - Writing low clears comparator enable, writing high sets it.
// - High fraction is 256 minus compare high over 256.
// - With comparator enable clear the output stays low.
module pwm8_channel (
    // Clock and reset
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_arst_n,
    input  wire logic                     i_ce,
    // Counter control
    input  wire logic                     i_counter_run,
    // Configuration
    input  wire logic [1:0]               i_cycle_length_select,
    input  wire pwm8_pkg::channel_mode_t  i_mode,
    input  wire pwm8_pkg::compare_write_t i_cmp_wr,
    // Flag clears from software
    input  wire logic                     i_clr_event_flag,
    input  wire logic                     i_clr_overflow_flag,
    // Outputs
    output logic                          o_channel_output_pin,
    output logic                          o_channel_event_flag,
    output logic                          o_cycle_overflow_flag,
    output logic [7:0]                    o_counter_low_byte,
    output pwm8_pkg::channel_state_t      o_state
);

    logic [7:0] counter_low_byte;
    logic       wrap;
    logic       comparator_enable;
    logic [7:0] compare_low_byte;
    logic [7:0] compare_high_byte;
    logic       mode_8bit;
    logic       match;
    logic       overflow;
    logic       next_pin;

    pwm8_timebase u_timebase (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_ce      (i_ce),
        .i_run     (i_counter_run),
        .o_count   (counter_low_byte),
        .o_wrap    (wrap)
    );

    // Shared length field gates every modulating channel alike
    assign mode_8bit = comparator_enable && i_mode.width_mod_select
        && (i_cycle_length_select == pwm8_pkg::CYCLE_LEN_8BIT);

    // Match is sampled only while counting so a halted counter holds the pin
    assign match = mode_8bit && i_counter_run
        && (counter_low_byte == compare_low_byte);
    assign overflow = wrap;

    // Overflow is the step to zero; a compare of zero then matches at once,
    // so the pin stays high for the full cycle
    always_comb begin
        next_pin = o_channel_output_pin;
        if (!mode_8bit) begin
            next_pin = 1'b0;
        end else if (match) begin
            next_pin = 1'b1;
        end else if (overflow) begin
            next_pin = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_channel_output_pin <= 1'b0;
        end else if (i_ce) begin
            o_channel_output_pin <= next_pin;
        end
    end

    // Compare pair and enable; a low write wins over the wrap reload
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            compare_low_byte  <= pwm8_pkg::BYTE_ZERO;
            compare_high_byte <= pwm8_pkg::BYTE_ZERO;
            comparator_enable <= 1'b0;
        end else if (i_ce) begin
            if (i_cmp_wr.wr_low) begin
                compare_low_byte  <= i_cmp_wr.wdata;
                comparator_enable <= 1'b0;
            end else if (wrap && mode_8bit) begin
                compare_low_byte  <= compare_high_byte;
            end
            if (i_cmp_wr.wr_high) begin
                compare_high_byte <= i_cmp_wr.wdata;
                comparator_enable <= 1'b1;
            end
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_channel_event_flag <= 1'b0;
        end else if (i_ce) begin
            if (match && !o_channel_output_pin
                && i_mode.match_flag_enable) begin
                o_channel_event_flag <= 1'b1;
            end else if (i_clr_event_flag) begin
                o_channel_event_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cycle_overflow_flag <= 1'b0;
        end else if (i_ce) begin
            if (overflow) begin
                o_cycle_overflow_flag <= 1'b1;
            end else if (i_clr_overflow_flag) begin
                o_cycle_overflow_flag <= 1'b0;
            end
        end
    end

    assign o_counter_low_byte = counter_low_byte;
    assign o_state = '{comparator_enable: comparator_enable,
                       compare_low_byte:  compare_low_byte,
                       compare_high_byte: compare_high_byte};

endmodule

// ===== test/pwm8_channel_properties.sv
// Purpose: Port timing checks of the 8-bit width modulation channel
// Assumes: One clock domain, reset low clears all state
// Notes:   Wrap effects get one edge of slack after the count at 0xff
`timescale 1ns/1ps
module pwm8_channel_properties (
    // Clock, reset and inputs
    input wire logic                     i_clk_sys,
    input wire logic                     i_arst_n,
    input wire logic                     i_ce,
    input wire logic                     i_counter_run,
    input wire logic [1:0]               i_cycle_length_select,
    input wire pwm8_pkg::channel_mode_t  i_mode,
    input wire pwm8_pkg::compare_write_t i_cmp_wr,
    // Outputs
    input wire logic                     o_channel_output_pin,
    input wire logic                     o_channel_event_flag,
    input wire logic                     o_cycle_overflow_flag,
    input wire logic [7:0]               o_counter_low_byte,
    input wire pwm8_pkg::channel_state_t o_state
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    logic on, step, nw;
    assign on = o_state.comparator_enable & i_mode.width_mod_select
                & (i_cycle_length_select == pwm8_pkg::CYCLE_LEN_8BIT);
    assign step = i_ce & i_counter_run;
    assign nw = !i_cmp_wr.wr_low & !i_cmp_wr.wr_high;
    sequence s_wrap;
        step && nw && o_counter_low_byte == pwm8_pkg::BYTE_MAX;
    endsequence
    a_count_step: assert property (step |=> o_counter_low_byte ==
        $past(o_counter_low_byte) + 8'h01) else $error("count step");
    a_match_sets: assert property (step && nw && on && o_counter_low_byte
        == o_state.compare_low_byte |=> o_channel_output_pin) else $error("match");
    a_mode_off: assert property (i_ce && nw && !on |=>
        !o_channel_output_pin) else $error("mode off");
    a_wrap_reload: assert property (s_wrap ##0 on |=> ##[0:1]
        o_state.compare_low_byte == o_state.compare_high_byte) else $error("reload");
    a_wrap_flag: assert property (s_wrap |=> ##[0:1] o_cycle_overflow_flag)
        else $error("overflow flag");
    a_wrap_low: assert property (s_wrap ##0 on && o_state.compare_high_byte >
        8'h01 && o_state.compare_low_byte != pwm8_pkg::BYTE_ZERO |=> ##[0:1]
        !o_channel_output_pin) else $error("pin not low");
    a_write_low: assert property (i_ce && i_cmp_wr.wr_low && !i_cmp_wr.wr_high
        |=> !o_state.comparator_enable && o_state.compare_low_byte ==
        $past(i_cmp_wr.wdata)) else $error("write low");
    a_write_high: assert property (i_ce && i_cmp_wr.wr_high
        |=> o_state.comparator_enable && o_state.compare_high_byte ==
        $past(i_cmp_wr.wdata)) else $error("write high");
    a_event_rise: assert property ($rose(o_channel_output_pin) &&
        $past(i_mode.match_flag_enable) |-> o_channel_event_flag) else $error("event");
endmodule
bind pwm8_channel pwm8_channel_properties i_chk (.i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n), .i_ce(i_ce), .i_counter_run(i_counter_run),
    .i_cycle_length_select(i_cycle_length_select), .i_mode(i_mode),
    .i_cmp_wr(i_cmp_wr), .o_channel_output_pin(o_channel_output_pin),
    .o_channel_event_flag(o_channel_event_flag), .o_state(o_state),
    .o_cycle_overflow_flag(o_cycle_overflow_flag),
    .o_counter_low_byte(o_counter_low_byte));

// ===== test/pwm8_channel_tb_top.sv
// Purpose: Directed checks of the 8-bit width modulation channel
// Assumes: Inputs move on the falling edge, writes only while stopped
// Notes:   Each window starts at count 1 so start-up transients drop out
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module pwm8_channel_tb_top;
    logic                     clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     run = 1'b0;
    logic                     ce = 1'b1;
    logic [7:0]               held;
    logic                     cev = 1'b0;
    logic                     cov = 1'b0;
    logic [1:0]               len = 2'h0;
    pwm8_pkg::channel_mode_t  mode = '0;
    pwm8_pkg::compare_write_t wr = '0;
    logic                     pin, ev, ov;
    logic [7:0]               cnt;
    pwm8_pkg::channel_state_t st;
    logic [7:0]               vals [3] = '{8'h00, 8'h80, 8'hff};
    int                       fails = 0;
    int                       tests_run = 0;
    int                       hi;
    always #5 clk = ~clk;
    pwm8_channel i_pwm8_channel (.i_clk_sys(clk), .i_arst_n(rst_n),
        .i_ce(ce), .i_counter_run(run), .i_cycle_length_select(len),
        .i_mode(mode), .i_cmp_wr(wr), .i_clr_event_flag(cev),
        .i_clr_overflow_flag(cov), .o_channel_output_pin(pin),
        .o_channel_event_flag(ev), .o_cycle_overflow_flag(ov),
        .o_counter_low_byte(cnt), .o_state(st));
    task automatic write(input logic lo, input logic hb, input logic [7:0] d);
        @(negedge clk);
        wr = '{lo, hb, d};
        @(negedge clk);
        wr = '0;
    endtask
    // Counts high cycles over one period from count 1, just after the fall,
    // so a partial first period cannot leak in; run must already be on
    task automatic measure();
        hi = 0;
        repeat (300) begin
            @(negedge clk);
            if (cnt === 8'h01) break;
        end
        repeat (256) begin
            hi += (pin === 1'b1);
            @(negedge clk);
        end
    endtask
    task automatic complete_run();
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        complete_run();
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        `CHK({pin, ev, ov, st.comparator_enable}, 4'h0)
        write(1'b1, 1'b0, 8'h40);
        `CHK({st.comparator_enable, st.compare_low_byte}, 9'h040)
        write(1'b0, 1'b1, 8'hc0);
        `CHK({st.comparator_enable, st.compare_high_byte}, 9'h1c0)
        $display("test writes done");
        mode = '{1'b1, 1'b1};
        foreach (vals[i]) begin
            write(1'b1, 1'b0, vals[i]);
            write(1'b0, 1'b1, vals[i]);
            run = 1'b1;
            measure();
            run = 1'b0;
            `CHK(hi, 256 - vals[i])
        end
        `CHK({ev, ov}, 2'h3)
        cev = 1'b1;
        cov = 1'b1;
        @(negedge clk);
        {cev, cov} = 2'h0;
        `CHK({ev, ov}, 2'h0)
        $display("test duty done");
        write(1'b1, 1'b0, 8'h10);
        run = 1'b1;
        measure();
        `CHK(hi, 0)
        run = 1'b0;
        write(1'b0, 1'b1, 8'h10);
        len = 2'h1;
        run = 1'b1;
        measure();
        `CHK(hi, 0)
        len = 2'h0;
        mode.width_mod_select = 1'b0;
        measure();
        `CHK(hi, 0)
        ce = 1'b0;
        held = cnt;
        repeat (5) @(negedge clk);
        `CHK(cnt, held)
        ce = 1'b1;
        $display("test mode off done");
        complete_run();
    end
endmodule
